// ---- hw/dli_pkg.sv ----
// package for the host-side controller of the dac input latch interface
package dli_pkg;

  // ***************************************************
  // software register map (word offsets on the plain port)
  // ***************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0; // w: mode and start
  localparam logic [3:0] REG_DATA   = 4'h1; // rw: 16-bit code to send
  localparam logic [3:0] REG_STATUS = 4'h2; // r: busy, done
  localparam logic [3:0] REG_LAST   = 4'h3; // r: data word at the end of the last dac step, zero after clear

  // ctrl field positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_WIDE   = 2;
  localparam int CTRL_CLEAR  = 3;
  localparam int CTRL_HOLD   = 4; // byte or word load fills input latches only, keeps dac latch

  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;

  localparam logic [15:0] DATA_RST = 16'h0000;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STROBE_MIN_NS  = 50;  // half of a 100 ns period at 10 MHz
  localparam int GAP_MIN_NS     = 20;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC0   = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC    = (GAP_CYC0 > STROBE_CYC) ? GAP_CYC0 : STROBE_CYC;
  localparam int SER_BITS   = 16;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_CLEAR
  } dli_state_t;

  // step being strobed
  typedef enum logic [1:0] {
    STEP_LOW, STEP_HIGH, STEP_SER, STEP_DAC
  } dli_step_t;

  // pins toward the converter
  typedef struct packed {
    logic       device_select_n;
    logic       write_strobe_n;
    logic       low_byte_enable_n;
    logic       high_byte_enable_n;
    logic       dac_latch_enable_n;
    logic       clear_n;
    logic [7:0] data_low;  // bit 0 doubles as lsb_or_serial_input
    logic [7:0] data_high; // upper byte, word variant only
  } dli_pins_t;

  typedef struct packed {
    dli_state_t  st;
    dli_step_t   step;
    logic [3:0]  cnt;
    logic [3:0]  bits;
    logic [15:0] data;
    logic [15:0] shift;
    logic [15:0] last;
    logic        serial;
    logic        wide;
    logic        hold;
    logic        done;
    logic [15:0] rdata;
    dli_pins_t   pins;
  } dli_regs_t;

  localparam dli_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00};

endpackage

// ---- hw/dli_host.sv ----
// host-side controller that loads the dac input latches over its pins
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module dli_host (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  // software port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [15:0]     reg_rdata,
  // converter pins
  output dli_pkg::dli_pins_t   dac_pins
);

  dli_pkg::dli_regs_t r_q;
  dli_pkg::dli_regs_t r_d;

  // ***************************************************
  // helper functions
  // ***************************************************
  // one step on the pins, edge by edge, from the entry into setup:
  //   setup edge    enables and data go out, strobe still high
  //   strobe edges  strobe low for STROBE_CYC cycles, enables and data held
  //   gap edges     strobe high for GAP_CYC cycles, enables still held
  //   last gap edge every pin returns to idle before the next setup
  // holding the enables through the gap gives the latches hold time after
  // the rising strobe; the price is one idle cycle between steps
  // a byte load is low, high, dac; a word load is word then dac; a serial
  // load is sixteen bit steps then dac; each step takes sixteen cycles

  // serial mode is refused on the word part, which has no shift register
  function automatic logic is_serial(input logic [15:0] w);
    is_serial = w[dli_pkg::CTRL_SERIAL] & ~w[dli_pkg::CTRL_WIDE];
  endfunction

  // control pins for one step; enables are driven low to act
  function automatic dli_pkg::dli_pins_t step_pins(input dli_pkg::dli_step_t s, input logic wide,
                                                   input logic [15:0] d, input logic sb);
    dli_pkg::dli_pins_t p;
    p = dli_pkg::PINS_IDLE;
    // select low on byte parts; word part has no select
    p.device_select_n = wide;
    case (s)
      dli_pkg::STEP_LOW: begin
        // low byte, or whole word on the wide part
        p.low_byte_enable_n = 1'b0;
        p.data_low          = d[7:0];
        p.data_high         = wide ? d[15:8] : 8'h00;
      end
      dli_pkg::STEP_HIGH: begin
        // the high byte travels on the low data lines of the byte part
        p.high_byte_enable_n = 1'b0;
        p.data_low           = d[15:8];
      end
      dli_pkg::STEP_SER: begin
        // both byte enables low selects serial
        p.low_byte_enable_n  = 1'b0;
        p.high_byte_enable_n = 1'b0;
        p.data_low           = {7'h00, sb};
      end
      default: begin
        // wide part takes its dac load on the second enable
        if (wide) begin
          p.high_byte_enable_n = 1'b0;
        end else begin
          p.dac_latch_enable_n = 1'b0;
        end
      end
    endcase
    return p;
  endfunction

  // next step after the one just strobed
  function automatic dli_pkg::dli_step_t next_step(input dli_pkg::dli_step_t s, input logic wide);
    // serial steps never come here; the gap state counts them itself
    case (s)
      dli_pkg::STEP_LOW: next_step = wide ? dli_pkg::STEP_DAC : dli_pkg::STEP_HIGH;
      default:           next_step = dli_pkg::STEP_DAC;
    endcase
  endfunction

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    r_d       = r_q;
    r_d.rdata = 16'h0000;
    // read data valid the cycle after the read strobe
    // busy comes straight from the state, so it never disagrees with the pins
    if (reg_rd) begin
      case (reg_addr)
        dli_pkg::REG_DATA:   r_d.rdata = r_q.data;
        dli_pkg::REG_STATUS: r_d.rdata = {14'h0000, r_q.done, r_q.st != dli_pkg::ST_IDLE};
        dli_pkg::REG_LAST:   r_d.rdata = r_q.last;
        default:             r_d.rdata = 16'h0000;
      endcase
    end
    // the data word may be rewritten mid-load; later byte steps then send the new word
    if (reg_wr && reg_addr == dli_pkg::REG_DATA) begin
      r_d.data = reg_wdata;
    end

    case (r_q.st)
      dli_pkg::ST_IDLE: begin
        r_d.pins = dli_pkg::PINS_IDLE;
        // control writes during a transfer are ignored, status shows busy
        if (reg_wr && reg_addr == dli_pkg::REG_CTRL) begin
          r_d.serial = is_serial(reg_wdata);
          r_d.wide   = reg_wdata[dli_pkg::CTRL_WIDE];
          r_d.hold   = reg_wdata[dli_pkg::CTRL_HOLD];
          r_d.cnt    = 4'h0;
          if (reg_wdata[dli_pkg::CTRL_CLEAR]) begin
            r_d.pins.clear_n = 1'b0;
            r_d.st   = dli_pkg::ST_CLEAR;
            r_d.done = 1'b0;
          end else if (reg_wdata[dli_pkg::CTRL_START]) begin
            r_d.step  = is_serial(reg_wdata) ? dli_pkg::STEP_SER : dli_pkg::STEP_LOW;
            r_d.shift = r_q.data;
            r_d.bits  = 4'h0;
            r_d.done  = 1'b0;
            r_d.st    = dli_pkg::ST_SETUP;
          end
        end
      end
      dli_pkg::ST_CLEAR: begin
        // clear fell at the start edge, so ending at STROBE_CYC - 1 gives STROBE_CYC low cycles
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt == 4'(dli_pkg::STROBE_CYC - 1)) begin
          r_d.pins = dli_pkg::PINS_IDLE;
          r_d.last = dli_pkg::DATA_RST;
          r_d.done = 1'b1;
          r_d.cnt  = 4'h0;
          r_d.st   = dli_pkg::ST_GAP;
        end
      end
      dli_pkg::ST_SETUP: begin
        // enables and data settle one cycle before the strobe falls
        // the serial bit is the top of a private copy, safe from data rewrites
        r_d.pins = step_pins(r_q.step, r_q.wide, r_q.data, r_q.shift[15]);
        r_d.st   = dli_pkg::ST_STROBE;
        r_d.cnt  = 4'h0;
      end
      dli_pkg::ST_STROBE: begin
        // strobe low captures into enabled latches
        r_d.pins.write_strobe_n = 1'b0;
        r_d.cnt = r_q.cnt + 4'h1;
        // strobe low time keeps the rate under 10 MHz
        // the strobe only falls at the first edge in this state, so the count runs
        // one further than in the clear state to give STROBE_CYC low cycles
        if (r_q.cnt == 4'(dli_pkg::STROBE_CYC)) begin
          r_d.pins.write_strobe_n = 1'b1;
          r_d.cnt = 4'h0;
          r_d.st  = dli_pkg::ST_GAP;
        end
      end
      dli_pkg::ST_GAP: begin
        r_d.cnt = r_q.cnt + 4'h1;
        // strobe high for the gap before the next enable
        if (r_q.cnt == 4'(dli_pkg::GAP_CYC - 1)) begin
          r_d.cnt  = 4'h0;
          r_d.pins = dli_pkg::PINS_IDLE;
          r_d.st   = dli_pkg::ST_SETUP;
          if (r_q.done) begin
            r_d.st = dli_pkg::ST_IDLE;
          end else if (r_q.step == dli_pkg::STEP_SER) begin
            // msb first, next bit moves to the top
            r_d.shift = {r_q.shift[14:0], 1'b0};
            r_d.bits  = r_q.bits + 4'h1;
            // sixteen strobes wrap the 4-bit count; bits at 15 moves on to the dac step
            if (r_q.bits == 4'(dli_pkg::SER_BITS - 1)) begin
              r_d.step = dli_pkg::STEP_DAC;
            end
          end else if (r_q.step == dli_pkg::STEP_DAC) begin
            // dac latch updated by its own strobe
            r_d.last = r_q.data;
            r_d.done = 1'b1;
            r_d.st   = dli_pkg::ST_IDLE;
          end else begin
            r_d.step = next_step(r_q.step, r_q.wide);
            // hold mode leaves the dac latch untouched
            if (r_q.hold && next_step(r_q.step, r_q.wide) == dli_pkg::STEP_DAC) begin
              r_d.done = 1'b1;
              r_d.st   = dli_pkg::ST_IDLE;
            end
          end
        end
      end
      // an illegal state falls back to idle with every pin released
      default: begin
        r_d.st   = dli_pkg::ST_IDLE;
        r_d.pins = dli_pkg::PINS_IDLE;
      end
    endcase
    // enables are never left low while idle, so no latch goes transparent
    // a serial load also needs select and both byte enables low on each bit strobe
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    // reset releases every pin at once, whatever step was in flight
    if (sys_rst) begin
      r_q <= '{dli_pkg::ST_IDLE, dli_pkg::STEP_LOW, 4'h0, 4'h0, dli_pkg::DATA_RST, 16'h0000,
               16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, dli_pkg::PINS_IDLE};
    end else begin
      r_q <= r_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  // pins and read data both come straight from flip-flops, free of glitches
  assign reg_rdata = r_q.rdata;
  assign dac_pins  = r_q.pins;

endmodule

// ---- test/dli_host_chk.sv ----
// port assertions for the dac latch host controller
`timescale 1ns/100ps
module dli_host_chk (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  // software port
  input wire logic [3:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  // converter pins
  input wire dli_pkg::dli_pins_t dac_pins
);
  // short aliases for the pin fields
  wire ws = dac_pins.write_strobe_n;
  wire le = dac_pins.low_byte_enable_n;
  wire he = dac_pins.high_byte_enable_n;
  wire de = dac_pins.dac_latch_enable_n;
  wire cl = dac_pins.clear_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_strobe_width: assert property ($fell(ws) |-> !ws [*7] ##1 ws)
    else $error("write strobe low time wrong");
  a_strobe_gap: assert property ($rose(ws) |-> ws [*7])
    else $error("write strobe gap too short");
  a_serial_select: assert property (!ws && !le && !he |-> !dac_pins.device_select_n)
    else $error("serial strobe without device select");
  a_strobe_enabled: assert property (!ws |-> !(le && he && de))
    else $error("strobe with no enable active");
  a_pins_steady: assert property (!ws && $past(!ws) |-> $stable(dac_pins))
    else $error("pins moved during strobe");
  a_dac_alone: assert property (!de |-> le && he)
    else $error("dac enable shares a strobe");
  a_clear_width: assert property ($fell(cl) |-> !cl [*7] ##1 cl)
    else $error("clear pulse length wrong");
  a_clear_quiet: assert property (!cl |-> ws && de)
    else $error("strobe during clear");
  // main scenarios reached
  c_clear: cover property ($fell(cl));
  c_serial: cover property (!ws && !le && !he);
  c_word: cover property (!ws && !he && dac_pins.device_select_n);
endmodule
bind dli_host dli_host_chk i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_pins(dac_pins));

// ---- test/dli_dev_model.sv ----
// behavioural model of the converter input and dac latches
`timescale 1ns/100ps
module dli_dev_model #(
  parameter bit WIDE = 1'b0
) (
  input wire dli_pkg::dli_pins_t p,
  output logic [15:0]            in_q,
  output logic [15:0]            dac_q
);
  // capture and clear
  // transparency folds into the value held when the strobe rises
  always @(posedge p.write_strobe_n or negedge p.clear_n) begin
    if (!p.clear_n) begin
      in_q  <= 16'h0000;
      dac_q <= 16'h0000;
    end else if (WIDE) begin
      if (!p.low_byte_enable_n)
        in_q <= {p.data_high, p.data_low};
      if (!p.high_byte_enable_n)
        dac_q <= in_q;
    end else if (!p.device_select_n) begin
      if (!p.low_byte_enable_n && !p.high_byte_enable_n)
        in_q <= {in_q[14:0], p.data_low[0]};
      else begin
        if (!p.low_byte_enable_n)
          in_q[7:0] <= p.data_low;
        if (!p.high_byte_enable_n)
          in_q[15:8] <= p.data_low;
      end
      if (!p.dac_latch_enable_n)
        dac_q <= in_q;
    end
  end
endmodule

// ---- test/dli_host_tb.sv ----
// self-checking bench for the dac latch host controller
`timescale 1ns/100ps
module dli_host_tb;
  logic               sys_clk;
  logic               sys_rst;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        reg_rdata;
  dli_pkg::dli_pins_t dac_pins;
  logic [15:0]        b_in;
  logic [15:0]        b_dac;
  logic [15:0]        w_dac;
  int                 failures = 0;
  int                 num_checks = 0;
  int                 strobes = 0;

  dli_host i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_pins(dac_pins));
  // one model per variant on the same pins; select keeps the byte model out of word loads
  dli_dev_model #(.WIDE(1'b0)) i_byte (.p(dac_pins), .in_q(b_in), .dac_q(b_dac));
  dli_dev_model #(.WIDE(1'b1)) i_word (.p(dac_pins), .in_q(), .dac_q(w_dac));

  // count rising write strobes for the serial pulse check
  always @(posedge dac_pins.write_strobe_n) begin
    strobes++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ***************************************************
  // bus tasks and checks
  // ***************************************************
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after each write so the strobe is never set twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask

  // load data, start, optionally poke a clear while busy, then poll
  task automatic run(input logic [15:0] c, input logic [15:0] d, input bit poke);
    logic [15:0] s;
    int          n;
    wr(4'h1, d);
    wr(4'h0, c);
    if (poke)
      wr(4'h0, 16'h0008);
    s = 16'h0001;
    n = 0;
    while (s[0] !== 1'b0 && n < 600) begin
      rd(4'h2, s);
      n++;
    end
    if (s[0] !== 1'b0) begin
      failures++;
      print_verdict();
    end
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    logic [15:0] q;
    rd(4'h1, q);
    chk(q, dli_pkg::DATA_RST);
    rd(4'hf, q);
    chk(q, 16'h0000);
  endtask

  task automatic t_byte;
    logic [15:0] q;
    run(16'h0001, 16'ha55a, 1'b1);
    chk(b_dac, 16'ha55a);
    rd(4'h3, q);
    chk(q, 16'ha55a);
    rd(4'h2, q);
    chk(q, 16'h0002);
  endtask

  task automatic t_hold;
    logic [15:0] q;
    run(16'h0011, 16'h1234, 1'b0);
    chk(b_in, 16'h1234);
    chk(b_dac, 16'ha55a);
    rd(4'h3, q);
    chk(q, 16'ha55a);
  endtask

  task automatic t_serial;
    int s0;
    s0 = strobes;
    run(16'h0003, 16'h8c31, 1'b0);
    chk(b_dac, 16'h8c31);
    chk(16'(strobes - s0), 16'h0011);
  endtask

  task automatic t_wide;
    run(16'h0005, 16'hbeef, 1'b0);
    chk(w_dac, 16'hbeef);
    chk(b_dac, 16'h8c31);
  endtask

  task automatic t_clear;
    logic [15:0] q;
    run(16'h0008, 16'h7777, 1'b0);
    chk(b_dac, 16'h0000);
    chk(b_in, 16'h0000);
    rd(4'h3, q);
    chk(q, 16'h0000);
  endtask

  // reset in mid-strobe: pins released at once, nothing loaded, registers cleared
  task automatic t_abort;
    logic [15:0] q;
    wr(4'h1, 16'h5555);
    wr(4'h0, 16'h0001);
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    num_checks++;
    if (dac_pins !== dli_pkg::PINS_IDLE) begin
      failures++;
      $display("MISMATCH t=%0t pins not idle after reset", $time);
    end
    chk(b_in, 16'h0000);
    chk(b_dac, 16'h0000);
    rd(4'h2, q);
    chk(q, 16'h0000);
    rd(4'h1, q);
    chk(q, dli_pkg::DATA_RST);
  endtask

  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_byte();
    t_hold();
    t_serial();
    t_wide();
    t_clear();
    t_abort();
    print_verdict();
  end
endmodule
